// ==== hdl/dasf_pkg.sv ====
// package for the dual converter serial frame: resolutions, edge counts,
// timing constants shared by both ends of the link.
// assumes a 125 MHz system clock on both ends.
package dasf_pkg;
  localparam int unsigned CLK_PERIOD_NS = 8;
  // resolution variants
  typedef enum logic [1:0] {DASF_RES16, DASF_RES14, DASF_RES12} dasf_res_t;
  localparam logic [4:0] RESULT_WIDTH_MAX = 5'h10;
  // falling edge on which the msb is launched and sampling resumes
  localparam logic [5:0] MSB_EDGE = 6'h0F;
  // last edge a full transfer needs, per variant (edge that carries lsb + 1)
  localparam logic [5:0] FULL_EDGES_16 = 6'h1F;
  localparam logic [5:0] FULL_EDGES_14 = 6'h1D;
  localparam logic [5:0] FULL_EDGES_12 = 6'h1B;
  // edge count saturates here so long frames never wrap
  localparam logic [5:0] EDGE_COUNT_MAX = 6'h3F;
  // host serial clock half period, in ns, rounded up to system clocks
  localparam int unsigned SCLK_HALF_NS = 64;
  localparam int unsigned SCLK_HALF_CYCLES =
    (SCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // select high time after a frame, covers the acquisition window
  localparam int unsigned SHORT_CYCLE_SELECT_HIGH_TIME_NS = 120;
  localparam int unsigned SHORT_CYCLE_SELECT_HIGH_CYCLES =
    (SHORT_CYCLE_SELECT_HIGH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SEL_HIGH_CYCLES_W =
    8'(SHORT_CYCLE_SELECT_HIGH_CYCLES);
  localparam logic [7:0] SCLK_HALF_CYCLES_W = 8'(SCLK_HALF_CYCLES);
endpackage

// ==== hdl/dasf_link_if.sv ====
// interface joining the converter end and the host end of the serial link.
// assumes the bench resolves the two data lines from data and enable.
`timescale 1ns/100ps
interface dasf_link_if;
  logic select_n;
  logic sclk;
  logic first_channel_serial_out;
  logic second_channel_serial_out;
  logic first_oe;
  logic second_oe;
  modport converter (
    input select_n, sclk,
    output first_channel_serial_out, second_channel_serial_out,
    output first_oe, second_oe
  );
  modport host (
    output select_n, sclk,
    input first_channel_serial_out, second_channel_serial_out,
    input first_oe, second_oe
  );
endinterface

// ==== hdl/dasf_sync.sv ====
// two flip-flop synchroniser with falling and rising edge pulses.
// assumes the input is asynchronous to clk_in.
`timescale 1ns/100ps
module dasf_sync
  import dasf_pkg::*;
#(
  parameter logic RESET_VALUE = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic async_in,
  output logic level_out,
  output logic fall_out,
  output logic rise_out
);
  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      meta_ff <= RESET_VALUE;
      sync_ff <= RESET_VALUE;
      last_ff <= RESET_VALUE;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
      last_ff <= sync_ff;
    end
  end
  assign level_out = sync_ff;
  assign fall_out = last_ff & ~sync_ff;
  assign rise_out = ~last_ff & sync_ff;
endmodule

// ==== hdl/dasf_converter.sv ====
// converter end: frame logic of the dual simultaneous-sampling converter.
// assumes results arrive on plain ports from the analog core model.
`timescale 1ns/100ps
module dasf_converter
  import dasf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  dasf_link_if.converter link,
  input wire dasf_res_t resolution_in,
  input wire logic [15:0] first_result_in,
  input wire logic [15:0] second_result_in,
  output logic sampling_out,
  output logic converting_out,
  output logic abort_out
);
  typedef enum logic [1:0] {DASF_IDLE, DASF_CONVERT, DASF_SHIFT} dasf_state_t;
  dasf_state_t state_ff, nxt_state;
  logic sel_level, sel_fall, sel_rise;
  logic sclk_level, sclk_fall, sclk_rise;
  logic [5:0] edge_ff, nxt_edge;
  logic sr_clear, sr_load, sr_shift;
  logic [15:0] result_w [2];
  logic [15:0] sr_ff [2];
  logic sampling_ff, nxt_sampling;
  logic abort_ff, nxt_abort;
  logic oe_ff, nxt_oe;
  logic [5:0] edge_inc;
  logic [4:0] res_shift;

  dasf_sync #(.RESET_VALUE(1'b1)) u_sel_sync (
    .clk_in(clk_in), .rst_in(rst_in), .async_in(link.select_n),
    .level_out(sel_level), .fall_out(sel_fall), .rise_out(sel_rise)
  );
  // reset to the idle level of sclk so no false edge follows reset
  dasf_sync #(.RESET_VALUE(1'b1)) u_sclk_sync (
    .clk_in(clk_in), .rst_in(rst_in), .async_in(link.sclk),
    .level_out(sclk_level), .fall_out(sclk_fall), .rise_out(sclk_rise)
  );

  // narrower variants hold their result in the low bits; left-align so the
  // msb always leaves from bit 15 and zeros follow the lsb
  assign res_shift = (resolution_in == DASF_RES14) ? 5'h02 :
                     (resolution_in == DASF_RES12) ? 5'h04 : 5'h00;
  assign result_w[0] = first_result_in;
  assign result_w[1] = second_result_in;
  assign edge_inc = (edge_ff == EDGE_COUNT_MAX) ? edge_ff : edge_ff + 6'h01;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_edge = edge_ff;
    sr_clear = 1'b0;
    sr_load = 1'b0;
    sr_shift = 1'b0;
    nxt_sampling = sampling_ff;
    nxt_abort = 1'b0;
    nxt_oe = oe_ff;
    case (state_ff)
      DASF_IDLE:
      begin
        if (sel_fall)
        begin
          nxt_state = DASF_CONVERT;
          nxt_edge = 6'h00;
          nxt_oe = 1'b1;
          sr_clear = 1'b1;
          nxt_sampling = 1'b0;
        end
      end
      DASF_CONVERT:
      begin
        if (sel_rise)
        begin
          // conversion dropped, track the new input at once
          nxt_state = DASF_IDLE;
          nxt_oe = 1'b0;
          nxt_sampling = 1'b1;
          nxt_abort = 1'b1;
        end
        else if (sclk_fall)
        begin
          nxt_edge = edge_inc;
          if (edge_inc == MSB_EDGE)
          begin
            nxt_state = DASF_SHIFT;
            nxt_sampling = 1'b1;
            sr_load = 1'b1;
          end
        end
      end
      DASF_SHIFT:
      begin
        if (sel_rise)
        begin
          // bits already out stay valid; nothing is recomputed
          nxt_state = DASF_IDLE;
          nxt_oe = 1'b0;
        end
        else if (sclk_fall)
        begin
          nxt_edge = edge_inc;
          sr_shift = 1'b1;
        end
      end
      default:
      begin
        nxt_state = DASF_IDLE;
        nxt_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= DASF_IDLE;
      edge_ff <= 6'h00;
    end
    else
    begin
      state_ff <= nxt_state;
      edge_ff <= nxt_edge;
    end
  end

  // tracking after reset, so the first frame converts a settled sample
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sampling_ff <= 1'b1;
      abort_ff <= 1'b0;
      oe_ff <= 1'b0;
    end
    else
    begin
      sampling_ff <= nxt_sampling;
      abort_ff <= nxt_abort;
      oe_ff <= nxt_oe;
    end
  end

  // both channels move on the same strobes, so the two lines can never
  // drift apart by a bit; a load outranks a shift in the same cycle
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : g_chan
      logic [15:0] aligned_w;
      logic [15:0] nxt_sr;
      assign aligned_w = result_w[ch] << res_shift;
      assign nxt_sr = sr_load ? aligned_w :
                      sr_shift ? {sr_ff[ch][14:0], 1'b0} :
                      sr_clear ? 16'h0000 : sr_ff[ch];
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
          sr_ff[ch] <= 16'h0000;
        else
          sr_ff[ch] <= nxt_sr;
      end
    end
  endgenerate

  // registered data: msb of the shift register, zero while converting
  assign link.first_channel_serial_out = sr_ff[0][15];
  assign link.second_channel_serial_out = sr_ff[1][15];
  assign link.first_oe = oe_ff;
  assign link.second_oe = oe_ff;
  assign sampling_out = sampling_ff;
  assign converting_out = (state_ff == DASF_CONVERT);
  assign abort_out = abort_ff;
endmodule

// ==== hdl/dasf_host.sv ====
// host end: runs one frame per start pulse, makes sclk by division and
// captures both result lines. assumes the converter end on the link.
`timescale 1ns/100ps
module dasf_host
  import dasf_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  dasf_link_if.host link,
  input wire logic start_in,
  input wire logic [5:0] edges_in,
  output logic busy_out,
  output logic done_out,
  output logic [15:0] first_data_out,
  output logic [15:0] second_data_out
);
  typedef enum logic [1:0] {DASF_H_IDLE, DASF_H_RUN, DASF_H_GAP} dasf_hstate_t;
  dasf_hstate_t state_ff, nxt_state;
  logic sel_n_ff, nxt_sel_n;
  logic sclk_ff, nxt_sclk;
  logic [7:0] div_ff, nxt_div;
  logic [5:0] count_ff, nxt_count;
  logic [5:0] target_ff, nxt_target;
  logic [15:0] first_ff, second_ff, nxt_first, nxt_second;
  logic [1:0] a_sync_ff, b_sync_ff;
  logic done_ff, nxt_done;
  logic tick;
  assign tick = (div_ff == 8'h00);

  // read lines through two flops; sample just before each falling edge from edge 16 on
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      a_sync_ff <= 2'b00;
      b_sync_ff <= 2'b00;
    end
    else
    begin
      a_sync_ff <= {a_sync_ff[0], link.first_channel_serial_out};
      b_sync_ff <= {b_sync_ff[0], link.second_channel_serial_out};
    end
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_sel_n = sel_n_ff;
    nxt_sclk = sclk_ff;
    nxt_div = tick ? 8'h00 : div_ff - 8'h01;
    nxt_count = count_ff;
    nxt_target = target_ff;
    nxt_first = first_ff;
    nxt_second = second_ff;
    nxt_done = 1'b0;
    case (state_ff)
      DASF_H_IDLE:
      begin
        if (start_in)
        begin
          nxt_state = DASF_H_RUN;
          nxt_sel_n = 1'b0;
          nxt_count = 6'h00;
          nxt_target = edges_in;
          nxt_first = 16'h0000;
          nxt_second = 16'h0000;
          nxt_div = SCLK_HALF_CYCLES_W;
          nxt_sclk = 1'b1;
        end
      end
      DASF_H_RUN:
      begin
        if (count_ff == target_ff && tick)
        begin
          nxt_state = DASF_H_GAP;
          nxt_sel_n = 1'b1;
          nxt_sclk = 1'b1;
          nxt_div = SEL_HIGH_CYCLES_W;
          nxt_done = 1'b1;
        end
        else if (tick)
        begin
          nxt_sclk = ~sclk_ff;
          nxt_div = SCLK_HALF_CYCLES_W;
          if (sclk_ff)
          begin
            nxt_count = count_ff + 6'h01;
            // bit launched on edge n is read at edge n+1
            if (count_ff >= MSB_EDGE)
            begin
              nxt_first = {first_ff[14:0], a_sync_ff[1]};
              nxt_second = {second_ff[14:0], b_sync_ff[1]};
            end
          end
        end
      end
      DASF_H_GAP:
      begin
        if (tick)
          nxt_state = DASF_H_IDLE;
      end
      default:
      begin
        nxt_state = DASF_H_IDLE;
        nxt_sel_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state_ff <= DASF_H_IDLE;
      sel_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      div_ff <= 8'h00;
      count_ff <= 6'h00;
      target_ff <= 6'h00;
      first_ff <= 16'h0000;
      second_ff <= 16'h0000;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sel_n_ff <= nxt_sel_n;
      sclk_ff <= nxt_sclk;
      div_ff <= nxt_div;
      count_ff <= nxt_count;
      target_ff <= nxt_target;
      first_ff <= nxt_first;
      second_ff <= nxt_second;
      done_ff <= nxt_done;
    end
  end

  assign link.select_n = sel_n_ff;
  assign link.sclk = sclk_ff;
  assign busy_out = (state_ff != DASF_H_IDLE);
  assign done_out = done_ff;
  assign first_data_out = first_ff;
  assign second_data_out = second_ff;
endmodule

// ==== bench/dasf_assertions.sv ====
// link checker for the dual converter serial frame.
// assumes plain link signals and one clock domain.
`timescale 1ns/100ps
module dasf_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic select_n,
  input wire logic sclk,
  input wire logic first_channel_serial_out,
  input wire logic second_channel_serial_out,
  input wire logic first_oe,
  input wire logic second_oe
);
  logic sclk_d_ff;
  logic sel_d_ff;
  logic [5:0] edge_cnt_ff;
  logic [3:0] since_fall_ff;
  wire fall_w = sclk_d_ff & ~sclk;
  wire zero_w = ~first_channel_serial_out & ~second_channel_serial_out;
  wire [5:0] nxt_edge_cnt = (sel_d_ff & ~select_n) ? 6'h00 :
    (fall_w & ~select_n & (edge_cnt_ff != 6'h3F)) ? edge_cnt_ff + 6'h01 :
    edge_cnt_ff;
  // saturates so the launch window test stays quiet between frames
  wire [3:0] nxt_since_fall = fall_w ? 4'h0 :
    (since_fall_ff == 4'hF) ? 4'hF : since_fall_ff + 4'h1;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      sclk_d_ff <= 1'b1;
      sel_d_ff <= 1'b1;
      edge_cnt_ff <= 6'h00;
      since_fall_ff <= 4'hF;
    end
    else
    begin
      sclk_d_ff <= sclk;
      sel_d_ff <= select_n;
      edge_cnt_ff <= nxt_edge_cnt;
      since_fall_ff <= nxt_since_fall;
    end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_driving_zero;
    first_oe && second_oe && zero_w;
  endsequence
  sequence s_gap_held;
    select_n [*8] ##1 select_n [*7];
  endsequence
  a_select_fall_drive: assert property ($fell(select_n) |-> ##[2:5] s_driving_zero)
    else $error("outputs not driven low after select fall");
  a_select_rise_float: assert property ($rose(select_n) |-> ##[2:5] (!first_oe && !second_oe))
    else $error("outputs still driven after select rise");
  a_idle_no_drive: assert property (select_n [*6] |-> (!first_oe && !second_oe))
    else $error("output driven outside a frame");
  a_convert_zeros: assert property ((first_oe && edge_cnt_ff < 6'h0F) |-> zero_w)
    else $error("nonzero output during conversion");
  a_pad_zeros: assert property ((first_oe && edge_cnt_ff > 6'h1F) |-> zero_w)
    else $error("nonzero output after last bit");
  a_launch_window: assert property ((first_oe && $past(first_oe) && $changed(first_channel_serial_out)) |-> (since_fall_ff inside {[1:8]}))
    else $error("data changed away from a clock fall");
  a_enables_paired: assert property (first_oe == second_oe)
    else $error("output enables differ");
  a_select_gap: assert property ($rose(select_n) |-> s_gap_held)
    else $error("select high time too short");
endmodule

// ==== bench/tb_dual_adc_serial_frame.sv ====
// self-checking bench: both link ends joined by the link interface.
// assumes the host end makes sclk and the converter answers it.
`timescale 1ns/100ps
module tb_dual_adc_serial_frame;
  import dasf_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  dasf_res_t res = DASF_RES16;
  logic [15:0] r1 = 16'h0000;
  logic [15:0] r2 = 16'h0000;
  logic start = 1'b0;
  logic [5:0] edges = 6'h00;
  logic busy, done, samp, conv, abort;
  logic [15:0] d1, d2;
  integer fails = 0;
  integer compares = 0;
  integer seed = 32'hC06E;
  int tab[4] = '{1, 14, 15, 16};
  dasf_link_if link ();
  // the interface has no wire, so the released line is resolved here
  wire line_a = link.first_oe ? link.first_channel_serial_out : 1'bz;
  wire line_b = link.second_oe ? link.second_channel_serial_out : 1'bz;
  dasf_converter dasf_converter_i (.clk_in(clk_in), .rst_in(rst_in),
    .link(link), .resolution_in(res), .first_result_in(r1),
    .second_result_in(r2), .sampling_out(samp), .converting_out(conv),
    .abort_out(abort));
  dasf_host dasf_host_i (.clk_in(clk_in), .rst_in(rst_in), .link(link),
    .start_in(start), .edges_in(edges), .busy_out(busy), .done_out(done),
    .first_data_out(d1), .second_data_out(d2));
  dasf_assertions dasf_assertions_i (.clk_in(clk_in), .rst_in(rst_in),
    .select_n(link.select_n), .sclk(link.sclk),
    .first_channel_serial_out(link.first_channel_serial_out),
    .second_channel_serial_out(link.second_channel_serial_out),
    .first_oe(link.first_oe), .second_oe(link.second_oe));
  initial
    forever #4 clk_in = ~clk_in;
  task automatic check(input string what, input logic [15:0] seen,
    input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // bits the host holds after n falling edges, msb first, zeros after lsb
  function automatic logic [15:0] model(input int w, input logic [15:0] v,
    input int n);
    logic [15:0] e;
    e = 16'h0000;
    for (int k = 16; k <= n; k++)
      e = {e[14:0], (k - 16 < w) ? v[w - 1 - (k - 16)] : 1'b0};
    return e;
  endfunction
  task automatic frame(input int r, input int n);
    int w;
    int t;
    logic [31:0] v;
    logic [15:0] a;
    logic [15:0] b;
    logic ab, lo, dn, cv;
    w = 16 - 2 * r;
    cv = 1'b0;
    ab = 1'b0;
    lo = 1'b0;
    dn = 1'b0;
    v = $random(seed);
    a = 16'($signed(v[15:0]) >>> (16 - w));
    b = 16'($signed(v[31:16]) >>> (16 - w));
    res <= dasf_res_t'(2'(r));
    r1 <= a;
    r2 <= b;
    edges <= 6'(n);
    start <= 1'b1;
    @(posedge clk_in);
    start <= 1'b0;
    for (t = 0; t < 4000 && !(dn && busy === 1'b0); t++)
    begin
      @(posedge clk_in);
      ab |= (abort === 1'b1);
      lo |= (samp === 1'b0);
      dn |= (done === 1'b1);
      cv |= (conv === 1'b1);
    end
    if (t == 4000)
    begin
      fails++;
      conclude();
    end
    check("first data", d1, model(w, a, n));
    check("second data", d2, model(w, b, n));
    check("abort", 16'(ab), 16'(n < 15));
    check("held", 16'(lo), 16'h0001);
    check("sampling", 16'(samp), 16'h0001);
    check("line", 16'(line_a), 16'(1'bz));
    check("line b", 16'(line_b), 16'(1'bz));
    check("converting", 16'(cv), 16'h0001);
    check("converting end", 16'(conv), 16'h0000);
    $display("frame res %0d edges %0d done", w, n);
  endtask
  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int r = 0; r < 3; r++)
      for (int k = 0; k < 6; k++)
        frame(r, (k < 4) ? tab[k] : 31 - 2 * r + (k - 4) * 3);
    conclude();
  end
endmodule
